// ---- hdl/uimd_edge_if.sv ----
/*
  Carrier between the control core and one input conditioner.
  Assumes the conditioner reads the polarity and drives level and edge.
*/
`timescale 1ns/1ps
interface uimd_edge_if;
  logic activeHigh;
  logic level;
  logic rise;
  modport core (input activeHigh, output level, output rise);
  modport user (output activeHigh, input level, input rise);
endinterface

// ---- hdl/uimd_pkg.sv ----
/*
  Shared constants, enumerations and state records for the user input,
  min/max capture and display control block.
  Assumes a single 250 MHz system clock; all times are counted in tenths
  of a second from one common tick.
*/
package uimd_pkg;

  // Timing base.
  localparam int CLK_PERIOD_NS = 4;
  localparam int TENTH_NS = 100000000;
  localparam int TENTH_CYCLES_DEF = (TENTH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int SCROLL_SEC = 4;
  localparam logic [7:0] SCROLL_TENTHS = 8'(SCROLL_SEC * 10);
  localparam int CAL_BUSY_SEC = 8;
  localparam logic [7:0] CAL_BUSY_TENTHS = 8'(CAL_BUSY_SEC * 10);
  localparam int MSG_SEC = 2;
  localparam logic [7:0] MSG_TENTHS = 8'(MSG_SEC * 10);

  // Service codes and calibration ranges.
  localparam logic [6:0] CODE_RESTORE = 7'h42;
  localparam logic [6:0] CODE_VERSION = 7'h32;
  localparam logic [6:0] CODE_CALIBRATE = 7'h30;
  localparam logic [3:0] CAL_RANGE_LAST = 4'h9;

  // Value limits and reset values.
  localparam logic signed [17:0] VALUE_LOW = -18'sd99999;
  localparam logic signed [17:0] VALUE_HIGH = 18'sd99999;
  localparam logic [2:0] INTENSITY_MIN = 3'h1;
  localparam logic [2:0] INTENSITY_MAX = 3'h5;
  localparam logic [2:0] INTENSITY_RST = 3'h5;
  // Arbitrary neutral identity values.
  localparam logic [15:0] MODEL_ID_WORD = 16'h0A5C;
  localparam logic [7:0] FW_VERSION_WORD = 8'h11;

  typedef enum logic [3:0] {
    UFN_NONE, UFN_PROG_LOCK, ZERO_INPUT_FN, UFN_RESET, DISPLAY_HOLD_FN,
    DISPLAY_ADVANCE_FN, UFN_INTENSITY, PRINT_REQUEST_FN, PRINT_THEN_CLEAR_FN,
    UFN_SP1_RESET, UFN_SP2_RESET, UFN_SP12_RESET
  } uimd_func_t;

  typedef enum logic [1:0] {ASN_LO, ASN_HI, ASN_BOTH, DISPLAY_TARGET_SETTING} uimd_assign_t;

  typedef enum logic [1:0] {SHOW_INPUT, SHOW_MAX, SHOW_MIN} uimd_show_t;

  typedef enum logic [2:0] {
    SVC_PROMPT, SVC_RESTORE_MSG, SVC_VERSION_MSG, CAL_RANGE_SEL,
    CAL_ZERO_WAIT, CAL_ZERO_BUSY, CAL_FULL_WAIT, CAL_FULL_BUSY
  } uimd_svc_t;

  typedef struct packed {
    // Fills with ones over the first two cycles after reset.
    logic [1:0] armed;
    logic syncA;
    logic syncB;
    logic level;
    logic rise;
  } uimd_edge_state_t;

endpackage

// ---- hdl/uimd_sync_edge.sv ----
/*
  Two-flop synchroniser, polarity normaliser and activation edge detector
  for one asynchronous contact.
  Assumes the contact is already debounced outside this block.
*/
`timescale 1ns/1ps
module uimd_sync_edge
  import uimd_pkg::*;
(
  // Clock and reset.
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic clkEn,
  // Raw contact.
  input wire logic pinIn,
  // Conditioned result.
  uimd_edge_if.core bus
);

  uimd_edge_state_t edge_reg;
  uimd_edge_state_t edge_next;

  // The first flop feeds only the second; polarity is applied after it.
  always_comb begin
    edge_next = edge_reg;
    edge_next.syncA = pinIn;
    edge_next.syncB = edge_reg.syncA;
    // The level stays inactive until the second flop holds a real sample, so an idle
    // active-low contact gives no false edge after reset.
    edge_next.armed = {edge_reg.armed[0], 1'b1};
    edge_next.level = edge_reg.armed[1] & (edge_reg.syncB ~^ bus.activeHigh);
    edge_next.rise = edge_next.level & ~edge_reg.level;
  end

  // All state freezes while the clock enable is low.
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      edge_reg <= '0;
    end else if (clkEn) begin
      edge_reg <= edge_next;
    end
  end

  assign bus.level = edge_reg.level;
  assign bus.rise = edge_reg.rise;

endmodule

// ---- hdl/uimd_user_input_ctrl.sv ----
/*
  User input decoder, front panel key handling, min/max capture, display
  selection, scroll, brightness, refresh pacing and service/calibration
  sequencing for a large process display.
  Assumes the input display value arrives already scaled on the system
  clock, and that print framing and setpoint logic sit outside and take
  one-cycle request pulses.
*/
`timescale 1ns/1ps
module uimd_user_input_ctrl
  import uimd_pkg::*;
#(
  parameter int TENTH_CYCLES = TENTH_CYCLES_DEF
)
(
  // Clock, reset and enable.
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic clkEn,
  // Contacts from the panel and the terminal block.
  input wire logic userInPin,
  input wire logic selKeyPin,
  input wire logic rstKeyPin,
  input wire logic menuEnterKey,
  // User input configuration.
  input wire uimd_func_t userFunc,
  input wire uimd_assign_t userAssign,
  input wire logic userActiveHigh,
  // Capture configuration.
  input wire logic maxEnable,
  input wire logic [13:0] maxDelayTenths,
  input wire logic minEnable,
  input wire logic [13:0] minDelayTenths,
  // Display and panel configuration.
  input wire logic [7:0] updateTenths,
  input wire logic selKeyEnable,
  input wire logic rstKeyEnable,
  input wire uimd_assign_t rstKeyAssign,
  input wire logic zeroWithReset,
  input wire logic scrollEnable,
  input wire logic [2:0] intensitySet,
  input wire logic intensityLoad,
  // Service code entry.
  input wire logic [6:0] serviceCode,
  input wire logic serviceEnter,
  // Measurement.
  input wire logic signed [17:0] inputDisplay,
  // Display side.
  output logic signed [17:0] inputOffset,
  output logic signed [17:0] maxValue,
  output logic signed [17:0] minValue,
  output logic signed [17:0] shownValue,
  output uimd_show_t shownSel,
  output logic [2:0] intensity,
  output logic holdActive,
  output logic progLock,
  // Request pulses.
  output logic printReq,
  output logic sp1Reset,
  output logic sp2Reset,
  output logic factoryRestore,
  output logic calZeroStart,
  output logic calFullStart,
  // Service status.
  output uimd_svc_t svcState,
  output logic [3:0] calRange,
  output logic calBusy,
  output logic [15:0] modelId,
  output logic [7:0] fwVersion
);

  typedef struct packed {
    logic [24:0] tickCnt;
    logic signed [17:0] offset;
    logic signed [17:0] maxVal;
    logic signed [17:0] minVal;
    logic signed [17:0] shown;
    logic [13:0] maxCnt;
    logic [13:0] minCnt;
    logic [7:0] updCnt;
    logic [7:0] scrollCnt;
    uimd_show_t sel;
    logic [2:0] level;
    logic hold;
    logic lock;
    logic clearPending;
    logic print;
    logic sp1;
    logic sp2;
    logic restore;
    logic calZero;
    logic calFull;
    uimd_svc_t svc;
    logic busy;
    logic [7:0] svcCnt;
    logic [3:0] range;
    logic [15:0] idWord;
    logic [7:0] verWord;
  } uimd_core_t;

  localparam uimd_core_t CORE_RST = '{
    tickCnt: '0, offset: '0, maxVal: VALUE_LOW, minVal: VALUE_HIGH, shown: '0,
    maxCnt: '0, minCnt: '0, updCnt: '0, scrollCnt: '0, sel: SHOW_INPUT,
    level: INTENSITY_RST, hold: 1'b0, lock: 1'b0, clearPending: 1'b0,
    print: 1'b0, sp1: 1'b0, sp2: 1'b0, restore: 1'b0, calZero: 1'b0,
    calFull: 1'b0, svc: SVC_PROMPT, busy: 1'b0, svcCnt: '0, range: '0, idWord: '0, verWord: '0
  };

  uimd_core_t core_reg;
  uimd_core_t core_next;

  logic [3:0] pinsIn;
  logic [3:0] riseV;
  logic [3:0] levelV;

  // Next enabled display; the input display is always enabled.
  function automatic uimd_show_t nextDisplay(input uimd_show_t cur, input logic maxOn, input logic minOn);
    uimd_show_t res;
    res = SHOW_INPUT;
    case (cur)
      SHOW_INPUT: begin
        res = maxOn ? SHOW_MAX : (minOn ? SHOW_MIN : SHOW_INPUT);
      end
      SHOW_MAX: begin
        res = minOn ? SHOW_MIN : SHOW_INPUT;
      end
      default: begin
        res = SHOW_INPUT;
      end
    endcase
    return res;
  endfunction

  // Reset mask {zero input, reset max, reset min} for one assignment.
  function automatic logic [2:0] resetMask(input uimd_assign_t asn, input uimd_show_t cur, input logic zeroOn);
    logic [2:0] m;
    m = 3'h0;
    case (asn)
      ASN_LO: begin
        m = 3'h1;
      end
      ASN_HI: begin
        m = 3'h2;
      end
      ASN_BOTH: begin
        m = 3'h3;
      end
      default: begin
        // The displayed target resets what is shown; input zeroes only when enabled.
        if (cur == SHOW_MAX) begin
          m = 3'h2;
        end else if (cur == SHOW_MIN) begin
          m = 3'h1;
        end else begin
          m = {zeroOn, 2'h0};
        end
      end
    endcase
    return m;
  endfunction

  // Does a hold on this assignment cover the given display.
  function automatic logic holdCovers(input uimd_assign_t asn, input uimd_show_t which, input uimd_show_t cur);
    logic c;
    c = 1'b0;
    case (asn)
      ASN_LO: c = (which == SHOW_MIN);
      ASN_HI: c = (which == SHOW_MAX);
      ASN_BOTH: c = (which != SHOW_INPUT);
      default: c = (which == cur);
    endcase
    return c;
  endfunction

  // Every contact goes through the same conditioner; only the user input
  // has a selectable polarity, the keys close to active high.
  assign pinsIn = {menuEnterKey, rstKeyPin, selKeyPin, userInPin};
  uimd_edge_if edgeBus [4] ();
  genvar gi;
  generate
    for (gi = 0; gi < 4; gi++) begin : g_edge
      assign edgeBus[gi].activeHigh = (gi == 0) ? userActiveHigh : 1'b1;
      assign riseV[gi] = edgeBus[gi].rise;
      assign levelV[gi] = edgeBus[gi].level;
      uimd_sync_edge u_edge (
        .mclk(mclk),
        .rst_n(rst_n),
        .clkEn(clkEn),
        .pinIn(pinsIn[gi]),
        .bus(edgeBus[gi])
      );
    end
  endgenerate

  // Whole next state; one pass decides every function for this cycle.
  always_comb begin
    logic tick;
    logic holdNow;
    logic holdMax;
    logic holdMin;
    logic holdShown;
    logic scrollOn;
    logic svcIdle;
    logic [2:0] mask;
    tick = 1'b0;
    holdNow = 1'b0;
    holdMax = 1'b0;
    holdMin = 1'b0;
    holdShown = 1'b0;
    scrollOn = 1'b0;
    svcIdle = 1'b0;
    mask = 3'h0;
    core_next = core_reg;
    core_next.print = 1'b0;
    core_next.sp1 = 1'b0;
    core_next.sp2 = 1'b0;
    core_next.restore = 1'b0;
    core_next.calZero = 1'b0;
    core_next.calFull = 1'b0;
    core_next.clearPending = 1'b0;

    // Tenth-second tick shared by every timer.
    tick = (core_reg.tickCnt == 25'(TENTH_CYCLES - 1));
    core_next.tickCnt = tick ? 25'h0 : core_reg.tickCnt + 25'h1;

    // Maintained functions follow the conditioned level directly.
    holdNow = (userFunc == DISPLAY_HOLD_FN) && levelV[0];
    holdMax = holdNow && holdCovers(userAssign, SHOW_MAX, core_reg.sel);
    holdMin = holdNow && holdCovers(userAssign, SHOW_MIN, core_reg.sel);
    holdShown = holdNow && holdCovers(userAssign, core_reg.sel, core_reg.sel);
    core_next.hold = holdNow;
    core_next.lock = (userFunc == UFN_PROG_LOCK) && levelV[0];
    svcIdle = (core_reg.svc == SVC_PROMPT);

    // Edge functions of the user input.
    if (riseV[0]) begin
      case (userFunc)
        ZERO_INPUT_FN: mask = 3'h4;
        UFN_RESET: mask = resetMask(userAssign, core_reg.sel, zeroWithReset);
        DISPLAY_ADVANCE_FN: core_next.sel = nextDisplay(core_reg.sel, maxEnable, minEnable);
        UFN_INTENSITY: begin
          core_next.level = (core_reg.level >= INTENSITY_MAX) ? INTENSITY_MIN : core_reg.level + 3'h1;
        end
        PRINT_REQUEST_FN: core_next.print = 1'b1;
        PRINT_THEN_CLEAR_FN: begin
          core_next.print = 1'b1;
          core_next.clearPending = 1'b1;
        end
        UFN_SP1_RESET: core_next.sp1 = 1'b1;
        UFN_SP2_RESET: core_next.sp2 = 1'b1;
        UFN_SP12_RESET: begin
          core_next.sp1 = 1'b1;
          core_next.sp2 = 1'b1;
        end
        default: begin
        end
      endcase
    end

    // The momentary reset lands one cycle after the print pulse.
    if (core_reg.clearPending) begin
      mask = mask | resetMask(userAssign, core_reg.sel, zeroWithReset);
    end

    // The select and reset key functions act only outside service and calibration.
    if (svcIdle && riseV[2] && rstKeyEnable) begin
      mask = mask | resetMask(rstKeyAssign, core_reg.sel, zeroWithReset);
    end
    if (svcIdle && riseV[1] && selKeyEnable) begin
      core_next.sel = nextDisplay(core_reg.sel, maxEnable, minEnable);
    end

    // A loaded level takes effect at once; out-of-range values are clamped.
    if (intensityLoad) begin
      if (intensitySet < INTENSITY_MIN) begin
        core_next.level = INTENSITY_MIN;
      end else if (intensitySet > INTENSITY_MAX) begin
        core_next.level = INTENSITY_MAX;
      end else begin
        core_next.level = intensitySet;
      end
    end

    // Scroll is meaningless with only the input display, so it is gated.
    scrollOn = scrollEnable && (maxEnable || minEnable);
    if (!scrollOn) begin
      core_next.scrollCnt = 8'h0;
    end else if (tick) begin
      if (core_reg.scrollCnt >= SCROLL_TENTHS - 8'h1) begin
        core_next.scrollCnt = 8'h0;
        core_next.sel = nextDisplay(core_reg.sel, maxEnable, minEnable);
      end else begin
        core_next.scrollCnt = core_reg.scrollCnt + 8'h1;
      end
    end

    // A display that was switched off falls back to the input display.
    if ((core_next.sel == SHOW_MAX && !maxEnable) || (core_next.sel == SHOW_MIN && !minEnable)) begin
      core_next.sel = SHOW_INPUT;
    end

    // Max capture: the delay filters out short spikes.
    if (!maxEnable || holdMax || inputDisplay <= core_reg.maxVal) begin
      core_next.maxCnt = 14'h0;
    end else if (tick) begin
      if (core_reg.maxCnt >= maxDelayTenths) begin
        core_next.maxVal = inputDisplay;
        core_next.maxCnt = 14'h0;
      end else begin
        core_next.maxCnt = core_reg.maxCnt + 14'h1;
      end
    end

    // Min capture mirrors max with its own enable and delay.
    if (!minEnable || holdMin || inputDisplay >= core_reg.minVal) begin
      core_next.minCnt = 14'h0;
    end else if (tick) begin
      if (core_reg.minCnt >= minDelayTenths) begin
        core_next.minVal = inputDisplay;
        core_next.minCnt = 14'h0;
      end else begin
        core_next.minCnt = core_reg.minCnt + 14'h1;
      end
    end

    // Resets win over a capture in the same cycle.
    if (mask[2]) begin
      core_next.offset = core_reg.offset - inputDisplay;
    end
    if (mask[1]) begin
      core_next.maxVal = inputDisplay;
      core_next.maxCnt = 14'h0;
    end
    if (mask[0]) begin
      core_next.minVal = inputDisplay;
      core_next.minCnt = 14'h0;
    end

    // Refresh pacing; an interval of zero refreshes every tick.
    if (tick) begin
      if (core_reg.updCnt + 8'h1 >= updateTenths) begin
        core_next.updCnt = 8'h0;
        if (!holdShown) begin
          case (core_reg.sel)
            SHOW_MAX: core_next.shown = core_reg.maxVal;
            SHOW_MIN: core_next.shown = core_reg.minVal;
            default: core_next.shown = inputDisplay;
          endcase
        end
      end else begin
        core_next.updCnt = core_reg.updCnt + 8'h1;
      end
    end

    // Service and calibration sequencing.
    case (core_reg.svc)
      SVC_PROMPT: begin
        core_next.svcCnt = 8'h0;
        if (serviceEnter) begin
          if (serviceCode == CODE_RESTORE) begin
            core_next.svc = SVC_RESTORE_MSG;
            core_next.restore = 1'b1;
          end else if (serviceCode == CODE_VERSION) begin
            core_next.svc = SVC_VERSION_MSG;
            core_next.idWord = MODEL_ID_WORD;
            core_next.verWord = FW_VERSION_WORD;
          end else if (serviceCode == CODE_CALIBRATE) begin
            core_next.svc = CAL_RANGE_SEL;
            core_next.range = 4'h0;
          end
        end
      end
      SVC_RESTORE_MSG, SVC_VERSION_MSG: begin
        if (tick) begin
          core_next.svcCnt = core_reg.svcCnt + 8'h1;
        end
        if (core_reg.svcCnt >= MSG_TENTHS) begin
          core_next.svc = SVC_PROMPT;
          core_next.idWord = 16'h0000;
          core_next.verWord = 8'h00;
        end
      end
      CAL_RANGE_SEL: begin
        core_next.svcCnt = 8'h0;
        if (riseV[2]) begin
          core_next.range = (core_reg.range >= CAL_RANGE_LAST) ? 4'h0 : core_reg.range + 4'h1;
        end
        if (riseV[3]) begin
          core_next.svc = (core_reg.range == 4'h0) ? SVC_PROMPT : CAL_ZERO_WAIT;
        end
      end
      CAL_ZERO_WAIT, CAL_FULL_WAIT: begin
        core_next.svcCnt = 8'h0;
        if (riseV[3]) begin
          core_next.svc = (core_reg.svc == CAL_ZERO_WAIT) ? CAL_ZERO_BUSY : CAL_FULL_BUSY;
          core_next.calZero = (core_reg.svc == CAL_ZERO_WAIT);
          core_next.calFull = (core_reg.svc == CAL_FULL_WAIT);
        end
      end
      CAL_ZERO_BUSY, CAL_FULL_BUSY: begin
        // Keys are ignored while a reading is being taken.
        if (tick) begin
          core_next.svcCnt = core_reg.svcCnt + 8'h1;
        end
        if (core_reg.svcCnt >= CAL_BUSY_TENTHS) begin
          core_next.svc = (core_reg.svc == CAL_ZERO_BUSY) ? CAL_FULL_WAIT : CAL_RANGE_SEL;
        end
      end
      default: begin
        core_next.svc = SVC_PROMPT;
      end
    endcase

    // Busy is registered beside the state so the output comes from a flop.
    core_next.busy = (core_next.svc == CAL_ZERO_BUSY) || (core_next.svc == CAL_FULL_BUSY);
  end

  // One register for the whole core; the enable freezes everything.
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      core_reg <= CORE_RST;
    end else if (clkEn) begin
      core_reg <= core_next;
    end
  end

  // Outputs are straight register fields.
  assign inputOffset = core_reg.offset;
  assign maxValue = core_reg.maxVal;
  assign minValue = core_reg.minVal;
  assign shownValue = core_reg.shown;
  assign shownSel = core_reg.sel;
  assign intensity = core_reg.level;
  assign holdActive = core_reg.hold;
  assign progLock = core_reg.lock;
  assign printReq = core_reg.print;
  assign sp1Reset = core_reg.sp1;
  assign sp2Reset = core_reg.sp2;
  assign factoryRestore = core_reg.restore;
  assign calZeroStart = core_reg.calZero;
  assign calFullStart = core_reg.calFull;
  assign svcState = core_reg.svc;
  assign calRange = core_reg.range;
  assign calBusy = core_reg.busy;
  assign modelId = core_reg.idWord;
  assign fwVersion = core_reg.verWord;

endmodule

// ---- tb/uimd_panel_model.sv ----
/* Panel keys and user input contact.
   Assumes the bench asks for presses as levels and sets the polarity. */
`timescale 1ns/1ps
module uimd_panel_model (
  // Clock.
  input logic mclk,
  // Presses: user input, select, reset key, menu enter.
  input logic [3:0] press,
  input logic activeHigh,
  // Contacts.
  output logic userInPin,
  output logic selKeyPin,
  output logic rstKeyPin,
  output logic menuEnterKey
);
  logic [3:0] held = 4'h0;
  // Closures land just after an edge, as a real contact would.
  always @(posedge mclk) begin
    held <= press;
  end
  // An open active-low contact rests high.
  assign userInPin = held[0] ~^ activeHigh;
  assign selKeyPin = held[1];
  assign rstKeyPin = held[2];
  // This key starts each calibration reading.
  assign menuEnterKey = held[3];
endmodule

// ---- tb/uimd_props.sv ----
/* Port-level checks for the user input control block.
   Assumes it is bound to uimd_user_input_ctrl and sees its ports only. */
`timescale 1ns/1ps
module uimd_props
  import uimd_pkg::*;
(
  // Clock and reset.
  input logic mclk,
  input logic rst_n,
  // Watched inputs.
  input logic userInPin,
  input logic userActiveHigh,
  input uimd_func_t userFunc,
  input uimd_assign_t userAssign,
  input logic [2:0] intensitySet,
  input logic intensityLoad,
  input logic [6:0] serviceCode,
  input logic serviceEnter,
  // Watched outputs.
  input logic signed [17:0] shownValue,
  input logic [2:0] intensity,
  input logic holdActive,
  input logic printReq,
  input logic sp1Reset,
  input logic sp2Reset,
  input logic factoryRestore,
  input logic calZeroStart,
  input uimd_svc_t svcState,
  input logic [15:0] modelId,
  input logic [7:0] fwVersion
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);
  // A print pulse lands exactly four cycles after the activating contact edge.
  property p_print;
    printReq |-> userFunc inside {PRINT_REQUEST_FN, PRINT_THEN_CLEAR_FN}
      && $past(userInPin, 4) == userActiveHigh && $past(userInPin, 5) != userActiveHigh;
  endproperty
  a_print: assert property (p_print) else $error("stray print pulse");
  property p_sp;
    (sp1Reset |-> userFunc inside {UFN_SP1_RESET, UFN_SP12_RESET})
      and (sp2Reset |-> userFunc inside {UFN_SP2_RESET, UFN_SP12_RESET});
  endproperty
  a_sp: assert property (p_sp) else $error("wrong setpoint cleared");
  // The shown value may not move while a hold on the displayed target stays on.
  property p_hold;
    holdActive && userAssign == DISPLAY_TARGET_SETTING ##1 holdActive
      |-> $stable(shownValue) && userFunc == DISPLAY_HOLD_FN;
  endproperty
  a_hold: assert property (p_hold) else $error("held value moved");
  property p_restore;
    serviceEnter && serviceCode == CODE_RESTORE && svcState == SVC_PROMPT
      |=> factoryRestore && svcState == SVC_RESTORE_MSG;
  endproperty
  a_restore: assert property (p_restore) else $error("restore code ignored");
  property p_version;
    svcState == SVC_VERSION_MSG |-> modelId == MODEL_ID_WORD && fwVersion == FW_VERSION_WORD;
  endproperty
  a_version: assert property (p_version) else $error("bad identity shown");
  property p_cal;
    calZeroStart |-> svcState == CAL_ZERO_BUSY && $past(svcState) == CAL_ZERO_WAIT;
  endproperty
  a_cal: assert property (p_cal) else $error("zero reading out of order");
  property p_load;
    intensityLoad && intensitySet inside {[3'h1:3'h5]} |=> intensity == $past(intensitySet);
  endproperty
  a_load: assert property (p_load) else $error("level not applied");
  // Any other change of level is one step up, wrapping from the top.
  property p_step;
    $changed(intensity) && !$past(intensityLoad) && !factoryRestore && !$past(factoryRestore)
      |-> intensity == (($past(intensity) == 3'h5) ? 3'h1 : $past(intensity) + 3'h1);
  endproperty
  a_step: assert property (p_step) else $error("level skipped");
  // Main scenarios reached.
  c_print: cover property (printReq);
  c_restore: cover property (factoryRestore);
  c_cal: cover property (calZeroStart);
endmodule

bind uimd_user_input_ctrl uimd_props u_props (.*);

// ---- tb/uimd_user_input_ctrl_tb_top.sv ----
/* Self-checking bench for the user input control block.
   Assumes the panel model works the contacts; one tick is ten cycles. */
`timescale 1ns/1ps
module uimd_user_input_ctrl_tb_top;
  import uimd_pkg::*;
  localparam int TC = 10;
  logic mclk = 1'b0, rst_n = 1'b0, clkEn = 1'b1, userActiveHigh = 1'b1, maxEnable = 1'b0, minEnable = 1'b0;
  logic selKeyEnable = 1'b1, rstKeyEnable = 1'b1, zeroWithReset = 1'b0, scrollEnable = 1'b0;
  logic intensityLoad = 1'b0, serviceEnter = 1'b0, userInPin, selKeyPin, rstKeyPin, menuEnterKey;
  logic holdActive, progLock, printReq, sp1Reset, sp2Reset, factoryRestore, calZeroStart, calFullStart, calBusy;
  logic [3:0] press = 4'h0, calRange;
  logic [13:0] maxDelayTenths = 14'h2, minDelayTenths = 14'h2;
  logic [7:0] updateTenths = 8'h1, fwVersion;
  logic [2:0] intensitySet = 3'h1, intensity;
  logic [6:0] serviceCode = 7'h0;
  logic [15:0] modelId;
  logic signed [17:0] inputDisplay = 18'sh32, inputOffset, maxValue, minValue, shownValue;
  uimd_func_t userFunc = UFN_NONE;
  uimd_assign_t userAssign = ASN_BOTH, rstKeyAssign = ASN_BOTH;
  uimd_show_t shownSel;
  uimd_svc_t svcState;
  uimd_func_t fn[4] = '{PRINT_REQUEST_FN, UFN_SP1_RESET, UFN_SP2_RESET, UFN_SP12_RESET};
  logic [2:0] ex[4] = '{3'h1, 3'h2, 3'h4, 3'h6};
  int n_errors = 0, samples_checked = 0;
  logic [7:0] seen;
  wire [7:0] fl = {progLock, calFullStart, svcState == CAL_FULL_WAIT, calZeroStart, svcState == SVC_PROMPT, sp2Reset,
    sp1Reset, printReq};

  uimd_user_input_ctrl #(.TENTH_CYCLES(TC)) uut (.*);
  uimd_panel_model panel (.*, .activeHigh(userActiveHigh));

  // Free-running 250 MHz clock.
  initial begin
    forever #2 mclk = ~mclk;
  end

  // Counts every comparison and reports a miss at once.
  task automatic chk(logic [17:0] got, logic [17:0] exp);
    samples_checked++;
    if (got !== exp) begin
      n_errors++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // Works contact k for n cycles and folds the pulses that follow into seen.
  task automatic act(int k, int n);
    seen = '0;
    press <= 4'(1 << k);
    for (int i = 0; i < n + 10; i++) begin
      @(posedge mclk);
      seen |= fl;
      if (i == n - 1) press <= 4'h0;
    end
  endtask

  // Waits a bounded time for flag i; running out ends the run.
  task automatic waitf(int i, int lim);
    int c;
    c = 0;
    while (fl[i] !== 1'b1 && c < lim) begin
      @(posedge mclk);
      c++;
    end
    chk(18'(c < lim), 18'h1);
    if (c >= lim) tally_and_finish();
  endtask

  // Keys in one service code with a one-cycle strobe.
  task automatic svc(logic [6:0] code);
    serviceCode <= code;
    serviceEnter <= 1'b1;
    @(posedge mclk);
    serviceEnter <= 1'b0;
    repeat (2) @(posedge mclk);
  endtask

  task automatic tally_and_finish();
    $display("checks %0d errors %0d", samples_checked, n_errors);
    if (n_errors == 0 && samples_checked > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  // Reset, then each function in turn; capture stays off until its own test.
  initial begin
    repeat (10) @(posedge mclk);
    rst_n <= 1'b1;
    repeat (6 * TC) @(posedge mclk);
    chk(maxValue, VALUE_LOW);
    chk(shownValue, 18'sh32);
    userFunc <= DISPLAY_HOLD_FN;
    userAssign <= DISPLAY_TARGET_SETTING;
    press <= 4'h1;
    repeat (8) @(posedge mclk);
    inputDisplay <= 18'sh3C;
    repeat (4 * TC) @(posedge mclk);
    chk(holdActive, 1'b1);
    chk(shownValue, 18'sh32);
    press <= 4'h0;
    repeat (4 * TC) @(posedge mclk);
    chk(shownValue, 18'sh3C);
    userFunc <= UFN_RESET;
    userAssign <= ASN_HI;
    act(0, 4);
    chk(maxValue, 18'sh3C);
    chk(minValue, VALUE_HIGH);
    // Key reset on the shown target zeroes the input while the input is shown.
    zeroWithReset <= 1'b1;
    rstKeyAssign <= DISPLAY_TARGET_SETTING;
    act(2, 4);
    chk(inputOffset, -18'sh3C);
    inputDisplay <= 18'sh28;
    userFunc <= PRINT_THEN_CLEAR_FN;
    act(0, 4);
    chk({seen[0], maxValue[16:0]}, 18'h20028);
    for (int i = 0; i < 4; i++) begin
      userFunc <= fn[i];
      act(0, 4);
      chk(seen[2:0], ex[i]);
    end
    // Polarity flips with the user input idle, so a glitch has no function.
    userActiveHigh <= 1'b0;
    userFunc <= UFN_NONE;
    repeat (10) @(posedge mclk);
    userFunc <= UFN_INTENSITY;
    act(0, 4);
    chk(intensity, INTENSITY_MIN);
    act(0, 4);
    chk(intensity, 3'h2);
    intensitySet <= 3'h4;
    intensityLoad <= 1'b1;
    @(posedge mclk);
    intensityLoad <= 1'b0;
    @(posedge mclk);
    chk(intensity, 3'h4);
    userFunc <= UFN_PROG_LOCK;
    act(0, 4);
    chk(seen[7], 1'b1);
    userFunc <= UFN_NONE;
    inputDisplay <= 18'sh46;
    maxEnable <= 1'b1;
    minEnable <= 1'b1;
    repeat (TC) @(posedge mclk);
    chk(maxValue, 18'sh28);
    repeat (5 * TC) @(posedge mclk);
    chk(maxValue, 18'sh46);
    chk(minValue, 18'sh46);
    userFunc <= DISPLAY_ADVANCE_FN;
    act(0, 4);
    chk(shownSel, SHOW_MAX);
    // The key resets only the shown maximum; the minimum keeps its capture.
    inputDisplay <= 18'sh50;
    act(2, 4);
    chk(maxValue, 18'sh50);
    chk(minValue, 18'sh46);
    act(1, 4);
    chk(shownSel, SHOW_MIN);
    userFunc <= ZERO_INPUT_FN;
    act(0, 4);
    chk(inputOffset, -18'sh8C);
    userFunc <= UFN_NONE;
    svc(CODE_VERSION);
    chk(modelId, MODEL_ID_WORD);
    chk(fwVersion, FW_VERSION_WORD);
    waitf(3, 50 * TC);
    svc(CODE_RESTORE);
    chk(svcState, SVC_RESTORE_MSG);
    waitf(3, 50 * TC);
    svc(CODE_CALIBRATE);
    act(2, 4);
    chk(calRange, 4'h1);
    act(3, 4);
    act(3, 4);
    chk({seen[4], calBusy}, 18'h3);
    waitf(5, 120 * TC);
    act(3, 4);
    chk({seen[6], calBusy}, 18'h3);
    // Scroll steps once per 40 ticks, so the first step lands 391 to 400 cycles on.
    scrollEnable <= 1'b1;
    repeat (38 * TC) @(posedge mclk);
    chk(shownSel, SHOW_MIN);
    repeat (3 * TC) @(posedge mclk);
    chk(shownSel, SHOW_INPUT);
    tally_and_finish();
  end
endmodule
